// ### logic/ncd_clkgen.sv
// Clock enable generator: system clock and instruction clock enables
`default_nettype none
module ncd_clkgen (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    // Control
    input  wire logic fast_sel_i,
    // Enables
    output logic      sys_en_o,
    output logic      inst_en_o
);
    logic [3:0] div_q;
    logic [1:0] quad_q;
    logic [3:0] ratio;

    assign ratio = fast_sel_i ? ncd_pkg::FAST_DIV : ncd_pkg::SLOW_DIV;

    // System clock enable: oscillator divided by eight, or undivided
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q    <= 4'h0;
            sys_en_o <= 1'b0;
        end else if (div_q + 4'h1 >= ratio) begin
            div_q    <= 4'h0;
            sys_en_o <= 1'b1;
        end else begin
            div_q    <= div_q + 4'h1;
            sys_en_o <= 1'b0;
        end
    end

    // Instruction clock enable: one in four system clock enables
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quad_q    <= 2'h0;
            inst_en_o <= 1'b0;
        end else begin
            inst_en_o <= 1'b0;
            if (sys_en_o) begin
                quad_q <= quad_q + 2'h1;
                inst_en_o <= (quad_q == ncd_pkg::INST_DIV);
            end
        end
    end
endmodule : ncd_clkgen
`default_nettype wire

// ### logic/ncd_core.sv
// Nibble datapath core: ALU, accumulator, carry, pair, pointer and stack
`default_nettype none
module ncd_core (
    // Clock and reset
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_b_i,
    // Instruction from decode
    input  wire ncd_pkg::ncd_instr_t            instr_i,
    input  wire logic                           instr_valid_i,
    // Data memory and program memory read data
    input  wire logic [ncd_pkg::DATA_W-1:0]     mem_rdata_i,
    input  wire logic [ncd_pkg::ROMW_W-1:0]     rom_rdata_i,
    // Memory request
    output logic [ncd_pkg::PC_W-1:0]            rom_addr_o,
    output logic                                mem_we_o,
    output logic [ncd_pkg::DATA_W-1:0]          mem_wdata_o,
    // State and timing
    output ncd_pkg::ncd_state_t                 state_o,
    output logic                                cmp_eq_o,
    output logic                                inst_en_o,
    output logic                                sys_en_o,
    output logic                                busy_o
);
    localparam int unsigned DW = ncd_pkg::DATA_W;
    localparam int unsigned IW = ncd_pkg::INPAGE_W;
    localparam int unsigned PW = ncd_pkg::PAGE_W;

    typedef enum logic [1:0] {
        NCD_ST_IDLE = 2'b00,
        NCD_ST_TBL  = 2'b01,
        NCD_ST_TRET = 2'b11
    } ncd_fsm_t;

    // ================================================================
    // Functions
    function automatic logic [DW:0] ncd_add(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b,
                                            input logic          ci);
        ncd_add = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, ci};
    endfunction : ncd_add

    function automatic logic [ncd_pkg::PC_W-1:0] ncd_tbl_addr(
            input logic [PW-1:0]               page,
            input logic [ncd_pkg::TPTR_W-1:0]  tp,
            input logic [DW-1:0]               a);
        ncd_tbl_addr = {page, tp, a};
    endfunction : ncd_tbl_addr

    // ================================================================
    // Registers
    logic [DW-1:0]                 acc_q;
    logic [DW-1:0]                 aux_q;
    logic [ncd_pkg::PAIR_W-1:0]    pair_q;
    logic [ncd_pkg::TPTR_W-1:0]    tptr_q;
    logic                          carry_q;
    logic                          urs_q;
    logic                          fast_q;
    logic [ncd_pkg::SP_W-1:0]      sp_q;
    logic [ncd_pkg::PC_W-1:0]      pc_q;
    logic [ncd_pkg::PC_W-1:0]      stack_q [ncd_pkg::STACK_N];
    ncd_fsm_t                      fsm_q;
    logic                          sys_en;
    logic                          inst_en;
    logic                          exec;
    ncd_pkg::ncd_op_t              op;
    logic [DW:0]                   sum;
    logic [ncd_pkg::SP_W-1:0]      sp_next;
    logic [ncd_pkg::PC_W-1:0]      pc_inc;

    // ================================================================
    // Clock enables
    ncd_clkgen u_clkgen (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .fast_sel_i (fast_q),
        .sys_en_o   (sys_en),
        .inst_en_o  (inst_en)
    );

    // One instruction per machine cycle
    assign exec    = inst_en && instr_valid_i && (fsm_q == NCD_ST_IDLE);
    assign op      = instr_i.op;
    assign sum     = ncd_add(acc_q, (op == ncd_pkg::NCD_OP_ADD_IMM) ? instr_i.imm : mem_rdata_i,
                             (op == ncd_pkg::NCD_OP_ADDMC) ? carry_q : 1'b0);
    assign sp_next = sp_q + 2'h1;
    assign pc_inc  = pc_q + 11'h001;

    // ================================================================
    // Accumulator
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_q <= 4'h0;
        end else if (exec) begin
            unique case (op)
                ncd_pkg::NCD_OP_ADD_IMM,
                ncd_pkg::NCD_OP_ADDM,
                ncd_pkg::NCD_OP_ADDMC:  acc_q <= sum[DW-1:0];
                ncd_pkg::NCD_OP_RRC:    acc_q <= {carry_q, acc_q[DW-1:1]};
                ncd_pkg::NCD_OP_LD_IMM: acc_q <= instr_i.imm;
                ncd_pkg::NCD_OP_LD_MEM: acc_q <= mem_rdata_i;
                ncd_pkg::NCD_OP_B2A:    acc_q <= aux_q;
                ncd_pkg::NCD_OP_E2BA:   acc_q <= pair_q[DW-1:0];
                default:                acc_q <= acc_q;
            endcase
        end
    end

    // ================================================================
    // Carry flag
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            carry_q <= 1'b0;
        end else if (exec) begin
            unique case (op)
                ncd_pkg::NCD_OP_ADDMC: carry_q <= sum[DW];
                ncd_pkg::NCD_OP_RRC:   carry_q <= acc_q[0];
                ncd_pkg::NCD_OP_SETC:  carry_q <= 1'b1;
                ncd_pkg::NCD_OP_CLRC:  carry_q <= 1'b0;
                default:               carry_q <= carry_q;
            endcase
        end else if (inst_en && fsm_q == NCD_ST_TBL && urs_q) begin
            carry_q <= rom_rdata_i[ncd_pkg::ROM_MSB];
        end
    end

    // ================================================================
    // Auxiliary, pair and table pointer registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aux_q  <= 4'h0;
            pair_q <= 8'h00;
            tptr_q <= 3'h0;
        end else if (exec) begin
            if (op == ncd_pkg::NCD_OP_A2B) begin
                aux_q <= acc_q;
            end
            if (op == ncd_pkg::NCD_OP_E2BA) begin
                aux_q <= pair_q[ncd_pkg::PAIR_W-1:DW];
            end
            if (op == ncd_pkg::NCD_OP_BA2E) begin
                pair_q <= {aux_q, acc_q};
            end
            if (op == ncd_pkg::NCD_OP_A2TP) begin
                tptr_q <= acc_q[ncd_pkg::TPTR_W-1:0];
            end
        end else if (inst_en && fsm_q == NCD_ST_TBL) begin
            pair_q <= rom_rdata_i[ncd_pkg::PAIR_W-1:0];
        end
    end

    // ================================================================
    // Upper-bit flag and clock select; only reset or backup clears them
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            urs_q  <= 1'b0;
            fast_q <= 1'b0;
        end else if (exec && op == ncd_pkg::NCD_OP_BACKUP) begin
            urs_q  <= 1'b0;
            fast_q <= 1'b0;
        end else if (exec && op == ncd_pkg::NCD_OP_SETURS) begin
            urs_q <= 1'b1;
        end else if (exec && op == ncd_pkg::NCD_OP_CLKSEL) begin
            fast_q <= 1'b1;
        end
    end

    // ================================================================
    // Program counter, stack and table read sequence
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_q  <= 11'h000;
            sp_q  <= ncd_pkg::SP_RESET;
            fsm_q <= NCD_ST_IDLE;
            for (int i = 0; i < ncd_pkg::STACK_N; i++) begin
                stack_q[i] <= 11'h000;
            end
        end else if (inst_en) begin
            unique case (fsm_q)
                NCD_ST_IDLE: begin
                    if (instr_valid_i) begin
                        pc_q <= pc_inc;
                        unique case (op)
                            ncd_pkg::NCD_OP_TBLRD: begin
                                sp_q          <= sp_next;
                                stack_q[sp_next] <= pc_inc;
                                pc_q          <= ncd_tbl_addr(instr_i.page, tptr_q, acc_q);
                                fsm_q         <= NCD_ST_TBL;
                            end
                            ncd_pkg::NCD_OP_LBRA: begin
                                pc_q <= ncd_tbl_addr(instr_i.page, tptr_q, acc_q);
                            end
                            ncd_pkg::NCD_OP_LCALLA: begin
                                sp_q             <= sp_next;
                                stack_q[sp_next] <= pc_inc;
                                pc_q <= ncd_tbl_addr(instr_i.page, tptr_q, acc_q);
                            end
                            ncd_pkg::NCD_OP_CALL: begin
                                sp_q             <= sp_next;
                                stack_q[sp_next] <= pc_inc;
                                pc_q             <= {instr_i.page, instr_i.addr};
                            end
                            ncd_pkg::NCD_OP_SPCALL: begin
                                sp_q             <= sp_next;
                                stack_q[sp_next] <= pc_inc;
                                pc_q             <= {ncd_pkg::CALL_PAGE, instr_i.addr};
                            end
                            ncd_pkg::NCD_OP_RET: begin
                                pc_q <= stack_q[sp_q];
                                sp_q <= sp_q - 2'h1;
                            end
                            ncd_pkg::NCD_OP_BACKUP: begin
                                sp_q <= ncd_pkg::SP_RESET;
                            end
                            default: begin
                                pc_q <= pc_inc;
                            end
                        endcase
                    end
                end
                NCD_ST_TBL: begin
                    fsm_q <= NCD_ST_TRET;
                end
                NCD_ST_TRET: begin
                    pc_q  <= stack_q[sp_q];
                    sp_q  <= sp_q - 2'h1;
                    fsm_q <= NCD_ST_IDLE;
                end
                default: begin
                    fsm_q <= NCD_ST_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Outputs
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_we_o    <= 1'b0;
            mem_wdata_o <= 4'h0;
            cmp_eq_o    <= 1'b0;
        end else begin
            mem_we_o <= 1'b0;
            if (exec) begin
                unique case (op)
                    ncd_pkg::NCD_OP_ST_MEM: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= acc_q;
                    end
                    ncd_pkg::NCD_OP_SETBIT: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= mem_rdata_i | (4'h1 << instr_i.bitsel);
                    end
                    ncd_pkg::NCD_OP_CLRBIT: begin
                        mem_we_o    <= 1'b1;
                        mem_wdata_o <= mem_rdata_i & ~(4'h1 << instr_i.bitsel);
                    end
                    ncd_pkg::NCD_OP_CMP: cmp_eq_o <= (acc_q == mem_rdata_i);
                    default: mem_wdata_o <= mem_wdata_o;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom_addr_o <= 11'h000;
            state_o    <= '0;
            inst_en_o  <= 1'b0;
            sys_en_o   <= 1'b0;
            busy_o     <= 1'b0;
        end else begin
            rom_addr_o <= pc_q;
            state_o    <= '{acc: acc_q, aux: aux_q, pair: pair_q, tptr: tptr_q,
                            carry: carry_q, upper_bit_reference_flag: urs_q, sp: sp_q};
            inst_en_o  <= inst_en;
            sys_en_o   <= sys_en;
            busy_o     <= (fsm_q != NCD_ST_IDLE);
        end
    end

    // ================================================================
    // Assertions
    property p_addc_carry;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_ADDMC |=> carry_q == $past(sum[DW]);
    endproperty
    a_addc_carry: assert property (p_addc_carry) else $error("carry wrong after add with carry");

    property p_add_keep;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && (op == ncd_pkg::NCD_OP_ADDM || op == ncd_pkg::NCD_OP_ADD_IMM) |=> $stable(carry_q);
    endproperty
    a_add_keep: assert property (p_add_keep) else $error("plain add changed carry");

    property p_rrc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_RRC |=> carry_q == $past(acc_q[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate did not load carry");

    property p_setc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_SETC |=> carry_q;
    endproperty
    a_setc: assert property (p_setc) else $error("set carry failed");

    property p_pair;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_BA2E |=> pair_q == {$past(aux_q), $past(acc_q)};
    endproperty
    a_pair: assert property (p_pair) else $error("pair load wrong");

    property p_call_sp;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_CALL |=> sp_q == $past(sp_q) + 2'h1;
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call did not advance pointer");

    property p_urs_sticky;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        urs_q && !(exec && op == ncd_pkg::NCD_OP_BACKUP) |=> urs_q;
    endproperty
    a_urs_sticky: assert property (p_urs_sticky) else $error("upper-bit flag cleared");

    property p_tbl_addr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_TBLRD
        |=> pc_q[IW-1:0] == {$past(tptr_q), $past(acc_q)} && fsm_q == NCD_ST_TBL;
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");

    c_tblrd: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_TBLRD && urs_q);
    c_addc: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_ADDMC && sum[DW]);
    c_wrap: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        exec && op == ncd_pkg::NCD_OP_CALL && sp_q == 2'h3);
endmodule : ncd_core
`default_nettype wire

// ### pkg/ncd_pkg.sv
// Package: opcodes, widths and timing constants for the nibble datapath core
`default_nettype none
package ncd_pkg;
    localparam int unsigned DATA_W    = 4;
    localparam int unsigned PAIR_W    = 8;
    localparam int unsigned TPTR_W    = 3;
    localparam int unsigned INPAGE_W  = 7;
    localparam int unsigned PAGE_W    = 4;
    localparam int unsigned PC_W      = PAGE_W + INPAGE_W;
    localparam int unsigned ROMW_W    = 9;
    localparam int unsigned ROM_MSB   = 8;
    localparam int unsigned SP_W      = 2;
    localparam int unsigned STACK_N   = 4;
    localparam logic [1:0]  SP_RESET  = 2'h3;
    localparam logic [3:0]  SLOW_DIV  = 4'h8;
    localparam logic [3:0]  FAST_DIV  = 4'h1;
    localparam logic [1:0]  INST_DIV  = 2'h3;
    localparam logic [PAGE_W-1:0] CALL_PAGE = 4'h2;

    typedef enum logic [4:0] {
        NCD_OP_NOP     = 5'h00,
        NCD_OP_ADD_IMM = 5'h01,
        NCD_OP_ADDM    = 5'h02,
        NCD_OP_ADDMC   = 5'h03,
        NCD_OP_RRC     = 5'h04,
        NCD_OP_SETC    = 5'h05,
        NCD_OP_CLRC    = 5'h06,
        NCD_OP_LD_IMM  = 5'h07,
        NCD_OP_LD_MEM  = 5'h08,
        NCD_OP_ST_MEM  = 5'h09,
        NCD_OP_A2B     = 5'h0A,
        NCD_OP_B2A     = 5'h0B,
        NCD_OP_BA2E    = 5'h0C,
        NCD_OP_E2BA    = 5'h0D,
        NCD_OP_A2TP    = 5'h0E,
        NCD_OP_TBLRD   = 5'h0F,
        NCD_OP_LBRA    = 5'h10,
        NCD_OP_LCALLA  = 5'h11,
        NCD_OP_CALL    = 5'h12,
        NCD_OP_SPCALL  = 5'h13,
        NCD_OP_RET     = 5'h14,
        NCD_OP_CLKSEL  = 5'h15,
        NCD_OP_SETURS  = 5'h16,
        NCD_OP_CMP     = 5'h17,
        NCD_OP_SETBIT  = 5'h18,
        NCD_OP_CLRBIT  = 5'h19,
        NCD_OP_BACKUP  = 5'h1A
    } ncd_op_t;

    typedef struct packed {
        ncd_op_t                   op;
        logic [DATA_W-1:0]         imm;
        logic [1:0]                bitsel;
        logic [PAGE_W-1:0]         page;
        logic [INPAGE_W-1:0]       addr;
    } ncd_instr_t;

    typedef struct packed {
        logic [DATA_W-1:0]         acc;
        logic [DATA_W-1:0]         aux;
        logic [PAIR_W-1:0]         pair;
        logic [TPTR_W-1:0]         tptr;
        logic                      carry;
        logic                      upper_bit_reference_flag;
        logic [SP_W-1:0]           sp;
    } ncd_state_t;
endpackage : ncd_pkg
`default_nettype wire

// ### tb/nibble_cpu_datapath_core_bench.sv
// Self-checking bench for the nibble datapath core
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module nibble_cpu_datapath_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals and design
    logic                            ref_clk_i;
    logic                            rst_b_i;
    ncd_pkg::ncd_instr_t             instr_i;
    logic                            instr_valid_i;
    logic [3:0]                      mem_rdata_i;
    logic [8:0]                      rom_rdata_i;
    logic [10:0]                     rom_addr_o;
    logic                            mem_we_o;
    logic [3:0]                      mem_wdata_o;
    ncd_pkg::ncd_state_t             state_o;
    logic                            cmp_eq_o;
    logic                            inst_en_o;
    logic                            sys_en_o;
    logic                            busy_o;
    int                              n_fail;
    int                              checks;
    logic                            chk_req;
    ncd_pkg::ncd_state_t             e;
    logic                            ecmp;
    logic [ncd_pkg::DATA_W+20:0]     q[$];
    logic [3:0]                      wq[$];
    logic [ncd_pkg::DATA_W+20:0]     qx;
    logic [3:0]                      wx;
    int                              p;

    ncd_core DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .mem_rdata_i(mem_rdata_i), .rom_rdata_i(rom_rdata_i),
        .rom_addr_o(rom_addr_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
        .state_o(state_o), .cmp_eq_o(cmp_eq_o), .inst_en_o(inst_en_o), .sys_en_o(sys_en_o),
        .busy_o(busy_o));

    // Table contents follow the low address byte so a wrong address in bits 7:0 shows in the pair
    assign rom_rdata_i = {rom_addr_o[0] ^ rom_addr_o[4], rom_addr_o[7:0] ^ 8'hA5};

    always #12.5 ref_clk_i = ~ref_clk_i;

    // ==========================================================
    // Result watcher
    always @(posedge ref_clk_i) begin
        if (chk_req) begin
            qx = q.pop_front();
            `CHK({cmp_eq_o, state_o}, qx)
        end
        if (mem_we_o === 1'b1) begin
            wx = (wq.size() > 0) ? wq.pop_front() : 4'hX;
            `CHK(mem_wdata_o, wx)
        end
    end

    // ==========================================================
    // Tasks
    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic wait_en();
        int n;
        n = 0;
        @(posedge ref_clk_i);
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (inst_en_o !== 1'b1 && n < 80);
        if (n >= 80) n_fail++;
    endtask : wait_en

    task automatic expect_now();
        q.push_back({ecmp, e});
        chk_req <= 1'b1;
        @(posedge ref_clk_i);
        chk_req <= 1'b0;
    endtask : expect_now

    task automatic step(input ncd_pkg::ncd_op_t op, input logic [3:0] im = 4'h0,
                        input logic [1:0] bs = 2'h0, input logic [3:0] pg = 4'h0,
                        input logic [3:0] md = 4'h0);
        logic [4:0]  s;
        logic [10:0] a;
        logic        seen;
        int          n;
        a = {pg, e.tptr, e.acc};
        seen = 1'b0;
        n = 0;
        s = {1'b0, e.acc} + {1'b0, md} + {4'h0, e.carry};
        case (op)
            ncd_pkg::NCD_OP_LD_IMM:  e.acc = im;
            ncd_pkg::NCD_OP_LD_MEM:  e.acc = md;
            ncd_pkg::NCD_OP_ADD_IMM: e.acc = e.acc + im;
            ncd_pkg::NCD_OP_ADDM:    e.acc = e.acc + md;
            ncd_pkg::NCD_OP_ADDMC:   {e.carry, e.acc} = s;
            ncd_pkg::NCD_OP_RRC:     {e.acc, e.carry} = {e.carry, e.acc};
            ncd_pkg::NCD_OP_SETC:    e.carry = 1'b1;
            ncd_pkg::NCD_OP_CLRC:    e.carry = 1'b0;
            ncd_pkg::NCD_OP_A2B:     e.aux = e.acc;
            ncd_pkg::NCD_OP_B2A:     e.acc = e.aux;
            ncd_pkg::NCD_OP_BA2E:    e.pair = {e.aux, e.acc};
            ncd_pkg::NCD_OP_E2BA:    {e.aux, e.acc} = e.pair;
            ncd_pkg::NCD_OP_A2TP:    e.tptr = e.acc[2:0];
            ncd_pkg::NCD_OP_CMP:     ecmp = (e.acc == md);
            ncd_pkg::NCD_OP_ST_MEM:  wq.push_back(e.acc);
            ncd_pkg::NCD_OP_SETBIT:  wq.push_back(md | (4'h1 << bs));
            ncd_pkg::NCD_OP_CLRBIT:  wq.push_back(md & ~(4'h1 << bs));
            ncd_pkg::NCD_OP_SETURS:  e.upper_bit_reference_flag = 1'b1;
            ncd_pkg::NCD_OP_RET:     e.sp = e.sp - 2'h1;
            ncd_pkg::NCD_OP_BACKUP:  begin e.upper_bit_reference_flag = 1'b0; e.sp = 2'h3; end
            ncd_pkg::NCD_OP_CALL, ncd_pkg::NCD_OP_SPCALL, ncd_pkg::NCD_OP_LCALLA:
                e.sp = e.sp + 2'h1;
            ncd_pkg::NCD_OP_TBLRD: begin
                e.pair = a[7:0] ^ 8'hA5;
                if (e.upper_bit_reference_flag) e.carry = a[0] ^ a[4];
            end
            default: ;
        endcase
        // Notes are queued before the op runs so the write watcher never finds them missing
        instr_i <= '{op: op, imm: im, bitsel: bs, page: pg, addr: 7'h00};
        mem_rdata_i <= md;
        instr_valid_i <= 1'b1;
        wait_en();
        instr_valid_i <= 1'b0;
        if (op == ncd_pkg::NCD_OP_TBLRD) begin
            @(posedge ref_clk_i);
            while (busy_o === 1'b1 && n < 300) begin
                seen = 1'b1;
                @(posedge ref_clk_i);
                n++;
            end
            `CHK(seen, 1'b1)
            wait_en();
        end
        expect_now();
    endtask : step

    task automatic per(input bit s, output int c);
        int n;
        n = 0;
        do begin @(posedge ref_clk_i); n++; end
        while ((s ? sys_en_o : inst_en_o) !== 1'b1 && n < 100);
        c = 0;
        do begin @(posedge ref_clk_i); c++; end
        while ((s ? sys_en_o : inst_en_o) !== 1'b1 && c < 100);
    endtask : per

    // ==========================================================
    // Watchdog
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial begin
        ncd_pkg::ncd_op_t ops[17];
        ops = '{ncd_pkg::NCD_OP_LD_IMM, ncd_pkg::NCD_OP_ADD_IMM, ncd_pkg::NCD_OP_ADDM,
            ncd_pkg::NCD_OP_ADDMC, ncd_pkg::NCD_OP_RRC, ncd_pkg::NCD_OP_SETC,
            ncd_pkg::NCD_OP_CLRC, ncd_pkg::NCD_OP_CMP, ncd_pkg::NCD_OP_SETBIT,
            ncd_pkg::NCD_OP_CLRBIT, ncd_pkg::NCD_OP_ST_MEM, ncd_pkg::NCD_OP_LD_MEM,
            ncd_pkg::NCD_OP_A2B, ncd_pkg::NCD_OP_B2A, ncd_pkg::NCD_OP_BA2E,
            ncd_pkg::NCD_OP_E2BA, ncd_pkg::NCD_OP_A2TP};
        ref_clk_i = 1'b0;
        rst_b_i = 1'b0;
        instr_i = '0;
        instr_valid_i = 1'b0;
        mem_rdata_i = 4'h0;
        chk_req = 1'b0;
        n_fail = 0;
        checks = 0;
        e = '0;
        e.sp = 2'h3;
        ecmp = 1'b0;
        void'($urandom(87));
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        expect_now();
        per(1'b0, p);
        `CHK(p, 32)
        per(1'b1, p);
        `CHK(p, 8)
        step(ncd_pkg::NCD_OP_CLKSEL);
        per(1'b0, p);
        `CHK(p, 4)
        per(1'b1, p);
        `CHK(p, 1)
        step(ncd_pkg::NCD_OP_LD_IMM, 4'hF);
        step(ncd_pkg::NCD_OP_SETC);
        step(ncd_pkg::NCD_OP_ADDMC, 4'h0, 2'h0, 4'h0, 4'h0);
        step(ncd_pkg::NCD_OP_ADD_IMM, 4'hF);
        step(ncd_pkg::NCD_OP_CMP, 4'h0, 2'h0, 4'h0, 4'hE);
        repeat (60) step(ops[$urandom % 17], 4'($urandom), 2'($urandom), 4'h0, 4'($urandom));
        step(ncd_pkg::NCD_OP_LD_IMM, 4'h5);
        step(ncd_pkg::NCD_OP_A2TP);
        step(ncd_pkg::NCD_OP_LD_IMM, 4'hE);
        step(ncd_pkg::NCD_OP_TBLRD, 4'h0, 2'h0, 4'h3);
        step(ncd_pkg::NCD_OP_SETURS);
        step(ncd_pkg::NCD_OP_TBLRD, 4'h0, 2'h0, 4'hC);
        step(ncd_pkg::NCD_OP_LD_IMM, 4'h7);
        step(ncd_pkg::NCD_OP_A2TP);
        step(ncd_pkg::NCD_OP_LD_IMM, 4'hF);
        step(ncd_pkg::NCD_OP_LBRA, 4'h0, 2'h0, 4'h6);
        `CHK(rom_addr_o, 11'h37F)
        step(ncd_pkg::NCD_OP_NOP);
        `CHK(rom_addr_o, 11'h380)
        repeat (5) step(ncd_pkg::NCD_OP_CALL, 4'h0, 2'h0, 4'h1);
        step(ncd_pkg::NCD_OP_LCALLA, 4'h0, 2'h0, 4'h4);
        step(ncd_pkg::NCD_OP_SPCALL);
        repeat (3) step(ncd_pkg::NCD_OP_RET);
        step(ncd_pkg::NCD_OP_BACKUP);
        per(1'b0, p);
        `CHK(p, 32)
        `CHK(wq.size(), 0)
        summarize();
    end
endmodule : nibble_cpu_datapath_core_bench
`default_nettype wire
